// File: sdc_pkg.sv
// Constants, register map and decode helper for the 8-bit down counter.
// Assumes one 40 MHz clock domain and an AXI4-Lite register bus.
package sdc_pkg;
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  localparam int CTRL_W = 5;
  localparam int CTRL_COUNT = 0;
  localparam int CTRL_SYNC_LOAD = 1;
  localparam int CTRL_ASYNC_LOAD = 2;
  localparam int CTRL_CLEAR = 3;
  localparam int CTRL_PRESET_SRC = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] PRESET_RST = 8'h00;

  localparam int STAT_W = 2;
  localparam int STAT_TERM = 0;
  localparam int STAT_LOAD = 1;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam int COUNT_TERM_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum {SDC_REG_CTRL, SDC_REG_PRESET, SDC_REG_COUNT, SDC_REG_STATUS, SDC_REG_MASK,
                SDC_REG_NONE} sdc_reg_e;

  // Word decode; the two low address bits are ignored
  function automatic sdc_reg_e sdc_decode(input logic [AXI_AW-1:0] addr);
    logic [AXI_AW-1:0] word;
    word = {addr[AXI_AW-1:2], 2'b00};
    case (word)
      OFS_CTRL: sdc_decode = SDC_REG_CTRL;
      OFS_PRESET: sdc_decode = SDC_REG_PRESET;
      OFS_COUNT: sdc_decode = SDC_REG_COUNT;
      OFS_STATUS: sdc_decode = SDC_REG_STATUS;
      OFS_MASK: sdc_decode = SDC_REG_MASK;
      default: sdc_decode = SDC_REG_NONE;
    endcase
  endfunction
endpackage

// File: sdc_ctl_if.sv
// Control and result bundle between the register front end and the counter core.
// Assumes both ends run on the same clock; all controls are active low.
`timescale 1ns/1ps
interface sdc_ctl_if;
  import sdc_pkg::*;
  logic clear_n;
  logic async_load_n;
  logic sync_load_n;
  logic count_enable_n;
  logic [CNT_W-1:0] preset_word;
  logic [CNT_W-1:0] count;
  logic terminal_count_n;
  logic term_event;
  logic load_event;

  modport core (
    input clear_n, async_load_n, sync_load_n, count_enable_n, preset_word,
    output count, terminal_count_n, term_event, load_event
  );
  modport ctl (
    output clear_n, async_load_n, sync_load_n, count_enable_n, preset_word,
    input count, terminal_count_n, term_event, load_event
  );
endinterface

// File: sdc_core.sv
// Counter core: 8-bit down counter with clear, two preset paths and terminal count.
// Assumes controls synchronous to sys_clk_i; reset doubles as a clear to maximum.
`timescale 1ns/1ps
module sdc_core
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Controls and results
  sdc_ctl_if.core ctl
);
  logic [CNT_W-1:0] next_count;
  logic next_term_n;
  logic counting;
  logic any_load;

  assign counting = ctl.clear_n && ctl.async_load_n && ctl.sync_load_n && !ctl.count_enable_n;
  assign any_load = !(ctl.clear_n && ctl.async_load_n && ctl.sync_load_n);

  // Inputs are sampled, so the forcing controls take hold at the next edge
  always_comb begin
    if (!ctl.clear_n) begin
      next_count = CNT_MAX;
    end else if (!ctl.async_load_n) begin
      next_count = ctl.preset_word;
    end else if (!ctl.sync_load_n) begin
      next_count = ctl.preset_word;
    end else if (!ctl.count_enable_n) begin
      next_count = ctl.count - CNT_ONE;
    end else begin
      next_count = ctl.count;
    end
  end

  // Low for the period in which the count sits at zero after an edge taken with the enable on
  assign next_term_n = !((next_count == CNT_ZERO) && !ctl.count_enable_n);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl.count <= CNT_MAX;
    end else begin
      ctl.count <= next_count;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl.terminal_count_n <= 1'b1;
      ctl.term_event <= 1'b0;
      ctl.load_event <= 1'b0;
    end else begin
      ctl.terminal_count_n <= next_term_n;
      ctl.term_event <= !next_term_n;
      ctl.load_event <= any_load;
    end
  end

  property p_count_down;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    counting |=> ctl.count == CNT_W'($past(ctl.count) - CNT_ONE);
  endproperty
  a_count_down: assert property (p_count_down) else $error("count did not step down");

  property p_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (!any_load && ctl.count_enable_n) |=> $stable(ctl.count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while disabled");

  property p_term;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (counting && ctl.count == CNT_ONE) |=> !ctl.terminal_count_n && ctl.count == CNT_ZERO;
  endproperty
  a_term: assert property (p_term) else $error("terminal count missing at zero");

  property p_sync_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ctl.clear_n && ctl.async_load_n && !ctl.sync_load_n) |=> ctl.count == $past(ctl.preset_word);
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("sync preset not taken");

  property p_async_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ctl.clear_n && !ctl.async_load_n) |=> ctl.count == $past(ctl.preset_word);
  endproperty
  a_async_load: assert property (p_async_load) else $error("forced preset not taken");

  property p_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctl.clear_n |=> ctl.count == CNT_MAX;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not give maximum");

  property p_precedence;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ctl.clear_n && !ctl.async_load_n && ctl.preset_word != CNT_MAX) |=> ctl.count == CNT_MAX;
  endproperty
  a_precedence: assert property (p_precedence) else $error("load overrode clear");

  property p_wrap;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (counting && ctl.count == CNT_ZERO) |=> ctl.count == CNT_MAX && ctl.terminal_count_n;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap from zero");

  property p_held_force;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ctl.clear_n && !ctl.async_load_n)[*3] ##0 $stable(ctl.preset_word) |=> $stable(ctl.count);
  endproperty
  a_held_force: assert property (p_held_force) else $error("held preset drifted");
endmodule

// File: sdc_top.sv
// Top of the down counter: pin controls, AXI4-Lite registers and interrupt.
// Assumes all pins synchronous to sys_clk_i and a single AXI4-Lite master.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module sdc_top
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Counter pins
  input wire logic count_enable_n_i,
  input wire logic sync_load_n_i,
  input wire logic async_load_n_i,
  input wire logic clear_to_max_n_i,
  input wire logic [CNT_W-1:0] preset_word_i,
  output logic terminal_count_n_o,
  output logic [CNT_W-1:0] count_o,
  // AXI4-Lite write
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Interrupt
  output logic irq_o
);
  sdc_ctl_if ctl ();

  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0] preset_reg;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [STAT_W-1:0] next_status;
  logic [STAT_W-1:0] next_mask;

  logic aw_held;
  logic w_held;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic lane0_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;
  logic [AXI_DW-1:0] rd_word;
  sdc_reg_e wr_sel;
  sdc_reg_e rd_sel;

  // Pin or register may assert each control; the merged control stays active low
  assign ctl.clear_n = clear_to_max_n_i && !ctrl[CTRL_CLEAR];
  assign ctl.async_load_n = async_load_n_i && !ctrl[CTRL_ASYNC_LOAD];
  assign ctl.sync_load_n = sync_load_n_i && !ctrl[CTRL_SYNC_LOAD];
  assign ctl.count_enable_n = count_enable_n_i && !ctrl[CTRL_COUNT];
  assign ctl.preset_word = ctrl[CTRL_PRESET_SRC] ? preset_reg : preset_word_i;

  sdc_core i_sdc_core (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ctl(ctl)
  );

  // Both come straight from core flops, so a next stage sees a clean level
  assign terminal_count_n_o = ctl.terminal_count_n;
  assign count_o = ctl.count;

  // Write path: address and data taken in either order, answered when both held
  assign aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  assign w_fire = s_axi_wvalid_i && s_axi_wready_o;
  assign do_write = aw_held && w_held && !s_axi_bvalid_o;
  assign lane0_write = do_write && wr_strb[0];
  assign next_aw_held = (aw_held && !do_write) || aw_fire;
  assign next_w_held = (w_held && !do_write) || w_fire;
  assign next_bvalid = (s_axi_bvalid_o && !s_axi_bready_i) || do_write;
  assign wr_sel = sdc_decode(wr_addr);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready_o <= !next_aw_held;
      s_axi_wready_o <= !next_w_held;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (aw_fire) begin
        wr_addr <= s_axi_awaddr_i;
      end
      if (w_fire) begin
        wr_data <= s_axi_wdata_i;
        wr_strb <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      s_axi_bvalid_o <= next_bvalid;
      if (do_write) begin
        s_axi_bresp_o <= (wr_sel == SDC_REG_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  // Control and preset registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RST;
      preset_reg <= PRESET_RST;
    end else begin
      if (lane0_write && wr_sel == SDC_REG_CTRL) begin
        ctrl <= wr_data[CTRL_W-1:0];
      end
      if (lane0_write && wr_sel == SDC_REG_PRESET) begin
        preset_reg <= wr_data[CNT_W-1:0];
      end
    end
  end

  // Sticky status: a hardware event in the clearing cycle survives the clear
  always_comb begin
    next_status = status;
    if (lane0_write && wr_sel == SDC_REG_STATUS) begin
      next_status = status & ~wr_data[STAT_W-1:0];
    end
    next_status[STAT_TERM] = next_status[STAT_TERM] | ctl.term_event;
    next_status[STAT_LOAD] = next_status[STAT_LOAD] | ctl.load_event;
  end

  always_comb begin
    next_mask = mask;
    if (lane0_write && wr_sel == SDC_REG_MASK) begin
      next_mask = wr_data[STAT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= STAT_RST;
      mask <= MASK_RST;
      irq_o <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq_o <= |(next_status & next_mask);
    end
  end

  // Read path: one read at a time, data registered at acceptance
  assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign next_rvalid = (s_axi_rvalid_o && !s_axi_rready_i) || ar_fire;
  assign rd_sel = sdc_decode(s_axi_araddr_i);

  always_comb begin
    rd_word = '0;
    case (rd_sel)
      SDC_REG_CTRL: rd_word[CTRL_W-1:0] = ctrl;
      SDC_REG_PRESET: rd_word[CNT_W-1:0] = preset_reg;
      SDC_REG_COUNT: begin
        rd_word[CNT_W-1:0] = ctl.count;
        rd_word[COUNT_TERM_BIT] = ctl.terminal_count_n;
      end
      SDC_REG_STATUS: rd_word[STAT_W-1:0] = status;
      SDC_REG_MASK: rd_word[STAT_W-1:0] = mask;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      s_axi_rvalid_o <= next_rvalid;
      s_axi_arready_o <= !next_rvalid;
      if (ar_fire) begin
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= (rd_sel == SDC_REG_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  property p_full_preset;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (clear_to_max_n_i && !ctrl[CTRL_CLEAR] && !async_load_n_i && !ctrl[CTRL_PRESET_SRC])
      |=> count_o == $past(preset_word_i);
  endproperty
  a_full_preset: assert property (p_full_preset) else $error("preset word not loaded whole");

  property p_pin_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !clear_to_max_n_i |=> count_o == CNT_MAX && terminal_count_n_o;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("low clear pin had no effect");

  property p_chain;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !terminal_count_n_o |-> count_o == CNT_ZERO && $past(ctl.count_enable_n) == 1'b0;
  endproperty
  a_chain: assert property (p_chain) else $error("terminal count low off zero");

  property p_write_answer;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (aw_fire && w_fire && !s_axi_bvalid_o) |-> ##2 s_axi_bvalid_o;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");

  property p_bvalid_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_read_count;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ar_fire && rd_sel == SDC_REG_COUNT)
      |=> s_axi_rvalid_o && s_axi_rdata_o[CNT_W-1:0] == $past(ctl.count);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count readback wrong");

  property p_rvalid_hold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");

  property p_sticky;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ctl.term_event |=> status[STAT_TERM];
  endproperty
  a_sticky: assert property (p_sticky) else $error("terminal event lost");

  property p_irq;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_o == |(status & mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with status");
endmodule

// File: sdc_next_stage.sv
// Next cascaded stage, a behavioural counter on the same clock.
// Assumes its enable is wired to the terminal count of the stage before.
`timescale 1ns/1ps
module sdc_next_stage
  import sdc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Chain input and count
  input wire logic count_enable_n_i,
  output logic [CNT_W-1:0] count_o
);
  // Synchronous chaining only; a ripple chain would clock on the terminal count
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= CNT_MAX;
    end else if (!count_enable_n_i) begin
      count_o <= count_o - CNT_ONE;
    end
  end
endmodule

// File: sync_down_counter_8bit_test.sv
// Self-checking bench for the down counter, its registers and interrupt.
// Assumes sdc_pkg, sdc_top and a next stage chained on the terminal count.
`timescale 1ns/1ps
module sync_down_counter_8bit_test;
  import sdc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cen_n = 1'b1;
  logic sl_n = 1'b1;
  logic al_n = 1'b1;
  logic clr_n = 1'b1;
  logic [7:0] pw = 8'h00;
  logic term_n;
  logic [7:0] cnt;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic irq;
  logic [7:0] ptn_cnt;
  logic [7:0] ptn_exp = 8'hff;
  logic [7:0] mcnt = 8'hff;
  logic [31:0] r;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h29c5_4991;
  logic [8:0] cq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];

  always #12.5 sys_clk = ~sys_clk;

  sdc_top i_sdc_top (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .count_enable_n_i(cen_n), .sync_load_n_i(sl_n),
    .async_load_n_i(al_n), .clear_to_max_n_i(clr_n), .preset_word_i(pw),
    .terminal_count_n_o(term_n), .count_o(cnt),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq)
  );

  sdc_next_stage i_sdc_next_stage (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .count_enable_n_i(term_n), .count_o(ptn_cnt)
  );

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    err_count++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask

  task automatic chk_cnt(input logic [8:0] e);
    n_compared++;
    if ({term_n, cnt} !== e) begin
      err_count++;
      $display("BAD %0t count got %h exp %h", $time, {term_n, cnt}, e);
    end
  endtask

  task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t read got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t value got %h exp %h", $time, g, e);
    end
  endtask

  // One pin cycle: drive, predict, note the expectation
  task automatic step(input logic c, input logic s, input logic a, input logic m,
                      input logic [7:0] p);
    logic [7:0] n;
    {cen_n, sl_n, al_n, clr_n, pw} <= {c, s, a, m, p};
    if (!m) n = CNT_MAX;
    else if (!a || !s) n = p;
    else if (!c) n = mcnt - CNT_ONE;
    else n = mcnt;
    mcnt = n;
    @(posedge sys_clk);
    cq.push_back({!(n == CNT_ZERO && !c), n});
    if (n == CNT_ZERO && !c) ptn_exp = ptn_exp - 8'h01;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    bq.push_back(e);
    {awaddr, awvalid, wdata, wvalid, bready} <= {a, 1'b1, d, 1'b1, 1'b1};
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 40) timeout();
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    {araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 40) timeout();
    @(posedge sys_clk);
  endtask

  // Interrupt flop updates on the edge of the register write; allow up to 4 edges
  task automatic irq_is(input logic e);
    int n;
    for (n = 0; n < 4 && irq !== e; n++) @(posedge sys_clk);
    chk_val({31'h0, irq}, {31'h0, e});
  endtask

  always @(negedge sys_clk) begin
    if (cq.size() > 0) begin
      chk_cnt(cq.pop_front());
    end
  end

  always @(posedge sys_clk) begin
    if (bvalid === 1'b1 && bready && bq.size() > 0) begin
      chk_val({30'h0, bresp}, {30'h0, bq.pop_front()});
    end
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      chk_rd({rresp, rdata}, rq.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk_cnt({1'b1, CNT_MAX});
    chk_val({31'h0, irq}, 32'h0000_0000);
    @(posedge sys_clk);
    step(1'b1, 1'b0, 1'b1, 1'b1, 8'h02);
    repeat (4) step(1'b0, 1'b1, 1'b1, 1'b1, 8'h55);
    repeat (3) step(1'b1, 1'b1, 1'b1, 1'b1, 8'h55);
    // Each control against every lower one
    step(1'b0, 1'b0, 1'b0, 1'b0, 8'h3c);
    step(1'b0, 1'b0, 1'b0, 1'b1, 8'hc3);
    step(1'b0, 1'b0, 1'b1, 1'b1, 8'h81);
    repeat (3) step(1'b0, 1'b1, 1'b0, 1'b1, 8'h7e);
    repeat (2) step(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    step(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    repeat (256) step(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    repeat (400) begin
      r = $random(seed);
      step(r[0], |r[3:1], |r[6:4], |r[10:7], r[23:16]);
    end
    step(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
    @(negedge sys_clk);
    @(posedge sys_clk);
    irq_is(1'b0);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0003});
    wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
    irq_is(1'b1);
    rd(OFS_MASK, {RESP_OKAY, 32'h0000_0001});
    wr(OFS_STATUS, 32'h0000_0001, RESP_OKAY);
    irq_is(1'b0);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0002});
    wr(OFS_MASK, 32'h0000_0003, RESP_OKAY);
    irq_is(1'b1);
    wr(OFS_STATUS, 32'h0000_0003, RESP_OKAY);
    irq_is(1'b0);
    rd(OFS_STATUS, {RESP_OKAY, 32'h0000_0000});
    rd(OFS_COUNT, {RESP_OKAY, 23'h0, 1'b1, mcnt});
    wr(OFS_COUNT, 32'h0000_0012, RESP_OKAY);
    rd(OFS_COUNT, {RESP_OKAY, 23'h0, 1'b1, mcnt});
    wr(OFS_PRESET, 32'h0000_00a5, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0012, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFS_COUNT, {RESP_OKAY, 32'h0000_01a5});
    rd(OFS_PRESET, {RESP_OKAY, 32'h0000_00a5});
    // Lane 0 strobe low must leave the preset alone
    wstrb <= 4'he;
    wr(OFS_PRESET, 32'h0000_003c, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_PRESET, {RESP_OKAY, 32'h0000_00a5});
    wr(OFS_CTRL, 32'h0000_0008, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(OFS_COUNT, {RESP_OKAY, 32'h0000_01ff});
    rd(OFS_CTRL, {RESP_OKAY, 32'h0000_0000});
    wr(8'h20, 32'h0000_00ff, RESP_DECERR);
    rd(8'h14, {RESP_DECERR, 32'h0000_0000});
    repeat (3) @(posedge sys_clk);
    chk_val({24'h0, ptn_cnt}, {24'h0, ptn_exp});
    complete_run();
  end
endmodule
